// [verilog/lhp_pkg.sv]
package lhp_pkg;

  // ----------------------------------------
  // bus styles
  // ----------------------------------------
  typedef enum logic [1:0] {
    LHP_ISA,
    LHP_X86,
    LHP_STROBE,
    LHP_PFETCH
  } lhp_style_e;

  // ----------------------------------------
  // widths and timing
  // ----------------------------------------
  localparam int ADDR_W        = 10;
  localparam int DATA_W        = 16;
  localparam int CLK_MHZ       = 25;
  localparam int ACCESS_NS     = 200;
  localparam int ACCESS_CYC    = (ACCESS_NS * CLK_MHZ + 999) / 1000;
  localparam int WAIT_CNT_W    = 8;
  localparam logic [ADDR_W-1:0] WIDE_BASE_RST = 10'h010;
  localparam logic [ADDR_W-1:0] WIDE_LAST_RST = 10'h01F;
  localparam logic [DATA_W-1:0] DATA_RST      = 16'h0000;

endpackage : lhp_pkg

// [verilog/lhp_sync.sv]
`timescale 1ns/1ns
module lhp_sync #(
  parameter int        WIDTH = 1,
  parameter logic      RST_V = 1'b0
) (
  input  wire logic             mclk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_q;

  // ----------------------------------------
  // two flop synchroniser
  // ----------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      stage1_q <= {WIDTH{RST_V}};
      syncOut  <= {WIDTH{RST_V}};
    end else begin
      stage1_q <= asyncIn;
      syncOut  <= stage1_q;
    end
  end

endmodule : lhp_sync

// [verilog/lhp_host_port.sv]
`timescale 1ns/1ns
// How it works
// - ten-bit host address selects I/O location
// - strobe mode ignores address bit zero
// - low high-byte enable activates upper lanes
// - strobe mode: shared pin is direction
// - sixteen-bit data driven only during reads
// - ISA and x86: interrupt active high
// - strobe and fetch modes: interrupt active low
// - ready low adds wait states during DMA
// - strobe mode: ready is low acknowledge
// - strobes count only under chip select
// - read strobe, or upper strobe in strobe mode
// - write strobe, or lower strobe in strobe mode
// - wide port indication in range, else released
// - ISA ignores cycles while DMA flag high
// - fetch mode accepts only while fetch pin high
module lhp_host_port #(
  parameter lhp_pkg::lhp_style_e    STYLE      = lhp_pkg::LHP_ISA,
  parameter int                     WAIT_CYC   = lhp_pkg::ACCESS_CYC,
  parameter logic [lhp_pkg::ADDR_W-1:0] WIDE_BASE = lhp_pkg::WIDE_BASE_RST,
  parameter logic [lhp_pkg::ADDR_W-1:0] WIDE_LAST = lhp_pkg::WIDE_LAST_RST
) (
  input  wire logic                        mclk,
  input  wire logic                        reset,
  input  wire logic [lhp_pkg::ADDR_W-1:0]  hostAddrIn,
  input  wire logic                        highByteEnableN,
  input  wire logic                        chipSelectN,
  input  wire logic                        ioReadStrobeN,
  input  wire logic                        ioWriteStrobeN,
  input  wire logic                        dmaCycleFlag,
  input  wire logic [lhp_pkg::DATA_W-1:0]  hostDataBusIn,
  output logic      [lhp_pkg::DATA_W-1:0]  hostDataBusOut,
  output logic      [lhp_pkg::DATA_W-1:0]  hostDataBusOe,
  output logic                             readyOut,
  output logic                             readyOe,
  output logic                             widePortIndN,
  output logic                             widePortIndOe,
  output logic                             irqOut,
  input  wire logic                        irqRequest,
  input  wire logic                        remoteDmaActive,
  output logic      [lhp_pkg::ADDR_W-1:0]  accAddr,
  output logic                             accUpper,
  output logic                             accLower,
  output logic                             accWrite,
  output logic      [lhp_pkg::DATA_W-1:0]  accWrData,
  output logic                             accStrobe,
  input  wire logic [lhp_pkg::DATA_W-1:0]  accRdData,
  input  wire logic                        accWideOk
);

  if (WAIT_CYC < 1 || WAIT_CYC > 255) begin : g_bad_wait
    $error("WAIT_CYC out of range");
  end
  if (WIDE_BASE > WIDE_LAST) begin : g_bad_wide
    $error("wide range inverted");
  end

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  localparam int PIN_W = lhp_pkg::ADDR_W + lhp_pkg::DATA_W + 5;

  logic [PIN_W-1:0]            pinsRaw;
  logic [PIN_W-1:0]            pinsSync;
  logic [lhp_pkg::ADDR_W-1:0]  addrS;
  logic [lhp_pkg::DATA_W-1:0]  dataS;
  logic                        bheS;
  logic                        csS;
  logic                        rdS;
  logic                        wrS;
  logic                        dmaS;

  assign pinsRaw = {hostAddrIn, hostDataBusIn, highByteEnableN, chipSelectN,
                    ioReadStrobeN, ioWriteStrobeN, dmaCycleFlag};

  lhp_sync #(
    .WIDTH (PIN_W),
    .RST_V (1'b1)
  ) u_sync (
    .mclk    (mclk),
    .reset   (reset),
    .asyncIn (pinsRaw),
    .syncOut (pinsSync)
  );

  assign {addrS, dataS, bheS, csS, rdS, wrS, dmaS} = pinsSync;

  // ----------------------------------------
  // cycle decode per bus style
  // ----------------------------------------
  logic                        enableOk;
  logic                        cycActive;
  logic                        cycWrite;
  logic                        laneUpper;
  logic                        laneLower;
  logic [lhp_pkg::ADDR_W-1:0]  addrEff;
  logic                        styleStrobe;

  assign styleStrobe = (STYLE == lhp_pkg::LHP_STROBE);

  always_comb begin
    enableOk  = 1'b1;
    cycActive = 1'b0;
    cycWrite  = 1'b0;
    laneUpper = 1'b0;
    laneLower = 1'b0;
    addrEff   = addrS;
    case (STYLE)
      lhp_pkg::LHP_ISA: begin
        enableOk = ~dmaS;
      end
      lhp_pkg::LHP_PFETCH: begin
        enableOk = dmaS;
      end
      default: begin
        enableOk = 1'b1;
      end
    endcase
    if (styleStrobe) begin
      addrEff   = {addrS[lhp_pkg::ADDR_W-1:1], 1'b0};
      laneUpper = ~rdS;
      laneLower = ~wrS;
      cycWrite  = ~bheS;
      cycActive = ~csS & enableOk & (laneUpper | laneLower);
    end else begin
      cycActive = ~csS & enableOk & (~rdS ^ ~wrS);
      cycWrite  = ~wrS;
      laneUpper = ~bheS;
      laneLower = (STYLE == lhp_pkg::LHP_PFETCH) ? 1'b1 : ~addrS[0];
    end
  end

  // ----------------------------------------
  // access sequencer
  // ----------------------------------------
  typedef enum logic [1:0] {
    IDLE,
    WAITING,
    DONE
  } lhp_state_e;

  lhp_state_e                    state_q;
  logic [lhp_pkg::WAIT_CNT_W-1:0] waitCnt_q;
  logic [lhp_pkg::DATA_W-1:0]    rdData_q;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_q   <= IDLE;
      waitCnt_q <= '0;
    end else begin
      case (state_q)
        IDLE: begin
          if (cycActive) begin
            if (remoteDmaActive) begin
              state_q   <= WAITING;
              waitCnt_q <= lhp_pkg::WAIT_CNT_W'(WAIT_CYC);
            end else begin
              state_q <= DONE;
            end
          end
        end
        WAITING: begin
          if (!cycActive) begin
            state_q <= IDLE;
          end else if (waitCnt_q <= lhp_pkg::WAIT_CNT_W'(1)) begin
            state_q <= DONE;
          end else begin
            waitCnt_q <= waitCnt_q - lhp_pkg::WAIT_CNT_W'(1);
          end
        end
        DONE: begin
          if (!cycActive) begin
            state_q <= IDLE;
          end
        end
        default: begin
          state_q <= IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // core access strobe and data capture
  // ----------------------------------------
  logic doAccess;

  assign doAccess = cycActive && ((state_q == IDLE && !remoteDmaActive) ||
                    (state_q == WAITING && waitCnt_q <= lhp_pkg::WAIT_CNT_W'(1)));

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      accStrobe <= 1'b0;
      accAddr   <= '0;
      accUpper  <= 1'b0;
      accLower  <= 1'b0;
      accWrite  <= 1'b0;
      accWrData <= lhp_pkg::DATA_RST;
    end else begin
      accStrobe <= doAccess;
      if (doAccess) begin
        accAddr   <= addrEff;
        accUpper  <= laneUpper;
        accLower  <= laneLower;
        accWrite  <= cycWrite;
        accWrData <= dataS;
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rdData_q <= lhp_pkg::DATA_RST;
    end else if (accStrobe && !accWrite) begin
      rdData_q <= accRdData;
    end
  end

  // ----------------------------------------
  // data bus drive
  // ----------------------------------------
  logic readPhase;

  assign readPhase = cycActive && !cycWrite && (state_q == DONE);

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      hostDataBusOut <= lhp_pkg::DATA_RST;
      hostDataBusOe  <= '0;
    end else begin
      // fresh core data so the bus is valid when ready or ack shows
      hostDataBusOut <= (accStrobe && !accWrite) ? accRdData : rdData_q;
      hostDataBusOe  <= {{8{readPhase & laneUpper}}, {8{readPhase & laneLower}}};
    end
  end

  // ----------------------------------------
  // ready, acknowledge and wide port
  // ----------------------------------------
  logic inWide;

  assign inWide = (addrEff >= WIDE_BASE) && (addrEff <= WIDE_LAST);

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      readyOut      <= 1'b1;
      readyOe       <= 1'b0;
      widePortIndN  <= 1'b1;
      widePortIndOe <= 1'b0;
    end else begin
      if (styleStrobe) begin
        readyOut <= ~(state_q == DONE && cycActive);
        readyOe  <= cycActive;
      end else begin
        readyOut <= ~(cycActive && state_q != DONE);
        readyOe  <= cycActive && (remoteDmaActive || state_q == WAITING);
      end
      widePortIndN  <= ~(~csS & enableOk & inWide & accWideOk);
      widePortIndOe <= ~csS & enableOk & inWide & accWideOk;
    end
  end

  // ----------------------------------------
  // interrupt polarity
  // ----------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      irqOut <= (STYLE == lhp_pkg::LHP_STROBE || STYLE == lhp_pkg::LHP_PFETCH);
    end else begin
      case (STYLE)
        lhp_pkg::LHP_STROBE, lhp_pkg::LHP_PFETCH: begin
          irqOut <= ~irqRequest;
        end
        default: begin
          irqOut <= irqRequest;
        end
      endcase
    end
  end

endmodule : lhp_host_port

// [tb/lhp_host_port_checker.sv]
`timescale 1ns/1ns
module lhp_host_port_checker #(
  parameter logic [9:0] WIDE_BASE = 10'h010,
  parameter logic [9:0] WIDE_LAST   = 10'h01F,
  parameter logic       STROBE_MODE = 1'b0,
  parameter logic       INV_IRQ     = 1'b0
) (
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic        chipSelectN,
  input wire logic        dmaCycleFlag,
  input wire logic [9:0]  hostAddrIn,
  input wire logic [15:0] hostDataBusIn,
  input wire logic [15:0] hostDataBusOe,
  input wire logic        readyOut,
  input wire logic        readyOe,
  input wire logic        widePortIndN,
  input wire logic        widePortIndOe,
  input wire logic        irqOut,
  input wire logic        irqRequest,
  input wire logic        accStrobe,
  input wire logic        accWrite,
  input wire logic        accLower,
  input wire logic [9:0]  accAddr,
  input wire logic [15:0] accWrData
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  sequence s_stall; readyOe && !readyOut; endsequence
  sequence s_resume; ##[1:8] readyOut; endsequence
  sequence s_take; $rose(accStrobe); endsequence
  property p_idle_oe; chipSelectN [*4] |-> hostDataBusOe == 16'h0000; endproperty
  property p_wr_oe; s_take ##0 accWrite |-> (hostDataBusOe == 16'h0000) [*4]; endproperty
  property p_pulse; accStrobe |=> !accStrobe; endproperty
  property p_cs; s_take |-> $past(chipSelectN, 2) == 1'b0; endproperty
  property p_dma; dmaCycleFlag [*5] |-> !accStrobe; endproperty
  property p_wdata;
    s_take ##0 accWrite |-> accAddr == {$past(hostAddrIn[9:1], 2), $past(hostAddrIn[0], 2) & !STROBE_MODE}
      && accWrData == $past(hostDataBusIn, 2);
  endproperty
  property p_lane; s_take |-> STROBE_MODE || accLower == !accAddr[0]; endproperty
  property p_irq; $stable(irqRequest) [*2] |-> irqOut == (irqRequest ^ INV_IRQ); endproperty
  property p_wait; s_stall |-> s_resume; endproperty
  property p_wide; widePortIndOe |-> !widePortIndN && $past(hostAddrIn, 3) inside {[WIDE_BASE:WIDE_LAST]}; endproperty
  a_idle_oe: assert property (p_idle_oe) else $error("data driven while idle");
  a_wr_oe: assert property (p_wr_oe) else $error("data driven in write");
  a_pulse: assert property (p_pulse) else $error("strobe longer than one cycle");
  a_cs: assert property (p_cs) else $error("access without select");
  a_dma: assert property (p_dma) else $error("access during dma flag");
  a_wdata: assert property (p_wdata) else $error("write address or data wrong");
  a_lane: assert property (p_lane) else $error("lower lane wrong");
  a_irq: assert property (p_irq) else $error("irq level wrong");
  a_wait: assert property (p_wait) else $error("wait not ended");
  a_wide: assert property (p_wide) else $error("wide indication wrong");
endmodule : lhp_host_port_checker

bind lhp_host_port lhp_host_port_checker #(
  .WIDE_BASE   (WIDE_BASE),
  .WIDE_LAST   (WIDE_LAST),
  .STROBE_MODE (STYLE == lhp_pkg::LHP_STROBE),
  .INV_IRQ     (STYLE == lhp_pkg::LHP_STROBE || STYLE == lhp_pkg::LHP_PFETCH)
) u_chk (.*);

// [tb/lhp_host_model.sv]
`timescale 1ns/1ns
module lhp_host_model (
  input wire logic        mclk,
  input wire logic        readyPin,
  input wire logic [15:0] busPin,
  output logic [9:0]      hostAddrIn,
  output logic            highByteEnableN,
  output logic            chipSelectN,
  output logic            ioReadStrobeN,
  output logic            ioWriteStrobeN,
  output logic [15:0]     hostDrv,
  output logic            hostDrvEn,
  output logic            sawWait
);
  initial begin
    hostAddrIn = 10'h000;
    highByteEnableN = 1'b1;
    chipSelectN = 1'b1;
    ioReadStrobeN = 1'b1;
    ioWriteStrobeN = 1'b1;
    hostDrv = 16'h0000;
    hostDrvEn = 1'b0;
    sawWait = 1'b0;
  end
  task automatic xfer(input logic csN, input logic wr, input logic [9:0] a, input logic [15:0] d,
                      output logic [15:0] q);
    int n;
    @(posedge mclk);
    chipSelectN <= csN;
    hostAddrIn <= a;
    highByteEnableN <= 1'b0;
    ioReadStrobeN <= wr;
    ioWriteStrobeN <= !wr;
    hostDrv <= d;
    hostDrvEn <= wr;
    sawWait = 1'b0;
    n = 0;
    // pins pass two flops, ready one register more
    repeat (4) @(posedge mclk);
    while (readyPin !== 1'b1 && n < 20) begin
      sawWait = 1'b1;
      n++;
      @(posedge mclk);
    end
    repeat (4) @(posedge mclk);
    q = busPin;
    chipSelectN <= 1'b1;
    ioReadStrobeN <= 1'b1;
    ioWriteStrobeN <= 1'b1;
    hostDrvEn <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask : xfer
endmodule : lhp_host_model

// [tb/testbench.sv]
`timescale 1ns/1ns
module testbench;
  logic mclk = 1'b0, reset = 1'b1, dmaCycleFlag = 1'b0, irqRequest = 1'b0, remoteDmaActive = 1'b0;
  logic accWideOk = 1'b1, highByteEnableN, chipSelectN, ioReadStrobeN, ioWriteStrobeN, hostDrvEn, sawWait;
  logic readyOut, readyOe, widePortIndN, widePortIndOe, irqOut, accUpper, accLower, accWrite, accStrobe;
  logic capUp, capLo, capWr, capWide;
  logic [9:0] hostAddrIn, accAddr, capAddr;
  logic [15:0] accRdData = 16'h0000, hostDataBusOut, hostDataBusOe, accWrData, hostDrv, capData, q;
  wire logic [15:0] busPin = (hostDataBusOe & hostDataBusOut) | (~hostDataBusOe & {16{hostDrvEn}} & hostDrv);
  wire logic [15:0] hostDataBusIn = busPin;
  wire logic readyPin = readyOe ? readyOut : 1'b1;
  int failures = 0, cmp_count = 0, cyc = 0, nStb = 0, n0;
  logic sCs = 1'b1, sDir = 1'b1, sUds = 1'b1, sLds = 1'b1, sRdy, sRdyOe, sWideN, sWideOe, sIrq;
  logic sAccUp, sAccLo, sAccWr;
  logic [9:0] sAddr = 10'h000, sAccAddr;
  logic [15:0] sData = 16'h0000, sBusOut, sBusOe, sAccWd;
  wire logic sRdyPin = sRdyOe ? sRdy : 1'b1;
  lhp_host_port #(.WAIT_CYC(2)) DUT (.*);
  lhp_host_model host (.*);
  lhp_host_port #(.STYLE(lhp_pkg::LHP_STROBE), .WAIT_CYC(2)) DUT_STB (
    .mclk            (mclk),
    .reset           (reset),
    .hostAddrIn      (sAddr),
    .highByteEnableN (sDir),
    .chipSelectN     (sCs),
    .ioReadStrobeN   (sUds),
    .ioWriteStrobeN  (sLds),
    .dmaCycleFlag    (dmaCycleFlag),
    .hostDataBusIn   (sData),
    .hostDataBusOut  (sBusOut),
    .hostDataBusOe   (sBusOe),
    .readyOut        (sRdy),
    .readyOe         (sRdyOe),
    .widePortIndN    (sWideN),
    .widePortIndOe   (sWideOe),
    .irqOut          (sIrq),
    .irqRequest      (irqRequest),
    .remoteDmaActive (remoteDmaActive),
    .accAddr         (sAccAddr),
    .accUpper        (sAccUp),
    .accLower        (sAccLo),
    .accWrite        (sAccWr),
    .accWrData       (sAccWd),
    .accStrobe       (),
    .accRdData       (accRdData),
    .accWideOk       (accWideOk)
  );
  always #20 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (accStrobe === 1'b1) begin
      nStb++;
      {capAddr, capData, capUp, capLo, capWr} = {accAddr, accWrData, accUpper, accLower, accWrite};
      capWide = widePortIndOe & !widePortIndN;
    end
    if (cyc == 6000) begin
      failures++;
      wrap_up();
    end
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wrap_up;
    if (failures == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up
  task t_rw;
    accRdData <= 16'h5A3C;
    host.xfer(1'b0, 1'b1, 10'h012, 16'hA5C3, q);
    chk({capWr, capUp, capLo}, 16'h0007);
    chk(capAddr, 16'h0012);
    chk(capData, 16'hA5C3);
    chk(capWide, 16'h0001);
    host.xfer(1'b0, 1'b0, 10'h025, 16'h0000, q);
    chk(q, 16'h5A00);
    chk({capWr, capUp, capLo}, 16'h0002);
    chk(capWide, 16'h0000);
  endtask : t_rw
  task t_refuse;
    n0 = nStb;
    host.xfer(1'b1, 1'b0, 10'h012, 16'h0000, q);
    chk(q, 16'h0000);
    chk(nStb, n0);
    dmaCycleFlag <= 1'b1;
    host.xfer(1'b0, 1'b1, 10'h013, 16'h1234, q);
    chk(nStb, n0);
    dmaCycleFlag <= 1'b0;
  endtask : t_refuse
  task t_wait;
    remoteDmaActive <= 1'b1;
    accRdData <= 16'h0F1E;
    host.xfer(1'b0, 1'b0, 10'h004, 16'h0000, q);
    chk(sawWait, 16'h0001);
    chk(q, 16'h0F1E);
    remoteDmaActive <= 1'b0;
  endtask : t_wait
  task t_irq;
    irqRequest <= 1'b1;
    repeat (4) @(posedge mclk);
    chk(irqOut, 16'h0001);
    chk(sIrq, 16'h0000);
    irqRequest <= 1'b0;
    repeat (4) @(posedge mclk);
    chk(irqOut, 16'h0000);
    chk(sIrq, 16'h0001);
  endtask : t_irq
  task stb_ack(input logic lvl);
    int nw;
    nw = 0;
    while (sRdyPin !== lvl && nw < 20) begin
      nw++;
      @(posedge mclk);
    end
    chk(nw < 20, 16'h0001);
  endtask : stb_ack
  task t_strobe;
    sAddr <= 10'h013;
    sDir <= 1'b0;
    sData <= 16'hC3A5;
    sUds <= 1'b0;
    sLds <= 1'b0;
    sCs <= 1'b0;
    stb_ack(1'b0);
    chk(sAccAddr, 16'h0012);
    chk({sAccWr, sAccUp, sAccLo}, 16'h0007);
    chk(sAccWd, 16'hC3A5);
    chk({sWideOe, sWideN}, 16'h0002);
    sCs <= 1'b1;
    sUds <= 1'b1;
    sLds <= 1'b1;
    stb_ack(1'b1);
    accRdData <= 16'h9C3C;
    sAddr <= 10'h020;
    sDir <= 1'b1;
    sUds <= 1'b0;
    sCs <= 1'b0;
    stb_ack(1'b0);
    chk(sBusOe & sBusOut, 16'h9C00);
    chk({sAccWr, sAccUp, sAccLo}, 16'h0002);
    sCs <= 1'b1;
    sUds <= 1'b1;
    stb_ack(1'b1);
    chk(sRdyOe, 16'h0000);
  endtask : t_strobe
  initial begin
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    chk({hostDataBusOe[14:0], readyOe}, 16'h0000);
    chk({widePortIndOe, irqOut}, 16'h0000);
    chk(sIrq, 16'h0001);
    t_rw();
    t_refuse();
    t_wait();
    t_irq();
    t_strobe();
    wrap_up();
  end
endmodule : testbench
